// ### pkg/pickup_cfg_map.svh
`ifndef PICKUP_CFG_MAP_SVH
`define PICKUP_CFG_MAP_SVH

// Register addresses carried in the top nibble of a word
`define ADDR_FOCUS 4'h2
`define ADDR_GAIN 4'h3
`define ADDR_PAIR 4'h4
`define ADDR_SUM 4'h5
`define ADDR_STATUS 4'hf
`define ADDR_FIRST 4'h2

// Address nibble position
`define ADDR_HI 15
`define ADDR_LO 12

// Focus offset control fields
`define FLD_ALT 11
`define FLD_FOFF_DIS 10
`define FLD_BETA_HI 9
`define FLD_BETA_LO 5

// RF gain fields
`define FLD_FIRST_HI 11
`define FLD_FIRST_LO 10
`define FLD_SECOND_HI 9
`define FLD_SECOND_LO 8
`define FLD_THIRD_HI 7
`define FLD_THIRD_LO 4
`define FIRST_RESERVED 2'h3

// Offset fields
`define FLD_LEFT_HI 11
`define FLD_LEFT_LO 6
`define FLD_RIGHT_HI 5
`define FLD_RIGHT_LO 0

// Bits that each register keeps; unused bits store as zero
`define MASK_FOCUS 16'h0fe0
`define MASK_GAIN 16'h0ff0
`define MASK_PAIR 16'h0fff
`define MASK_SUM 16'h003f

// Reset words; focus full-range source starts disabled
`define RST_FOCUS 16'h2400
`define RST_GAIN 16'h3000
`define RST_PAIR 16'h4000
`define RST_SUM 16'h5000
`define OFFSET_ZERO 6'h00
`define RDATA_ZERO 16'h0000

`endif

// ### pkg/pickup_cfg_pkg.sv
package pickup_cfg_pkg;
    typedef logic [15:0] cfg_word_t;
    typedef logic [5:0] offset_code_t;
    // How the offset fields are interpreted
    typedef enum logic [1:0] {
        ROUTE_DIODE,
        ROUTE_SUM_SHARED,
        ROUTE_SUM_SPLIT
    } route_e;
endpackage

// ### hw/cfg_word_decode.sv
`include "pickup_cfg_map.svh"
module cfg_word_decode #(
    parameter int NUM_REGS = 4
) (
    // Write side
    input wire logic wr,
    input wire pickup_cfg_pkg::cfg_word_t word,
    // One load strobe per register, starting at the first address
    output logic [NUM_REGS-1:0] load
);
    genvar i;
    // Compare the word's address nibble with each register address
    generate
        for (i = 0; i < NUM_REGS; i++) begin : g_dec
            assign load[i] = wr && (word[`ADDR_HI:`ADDR_LO] == (`ADDR_FIRST + 4'(i)));
        end
    endgenerate
endmodule

// ### hw/rf_offset_route.sv
`include "pickup_cfg_map.svh"
module rf_offset_route (
    // Mode selects
    input wire logic summed_input_select,
    input wire logic phase_offset_source_select,
    // Stored offset words
    input wire pickup_cfg_pkg::cfg_word_t pair_word,
    input wire pickup_cfg_pkg::cfg_word_t sum_word,
    // Routed codes
    output pickup_cfg_pkg::offset_code_t left_code,
    output pickup_cfg_pkg::offset_code_t right_code,
    output pickup_cfg_pkg::offset_code_t summed_code,
    output pickup_cfg_pkg::offset_code_t phase_code,
    output pickup_cfg_pkg::route_e mode
);
    pickup_cfg_pkg::offset_code_t hi_field;
    pickup_cfg_pkg::offset_code_t lo_field;
    pickup_cfg_pkg::offset_code_t s_field;

    assign hi_field = pair_word[`FLD_LEFT_HI:`FLD_LEFT_LO];
    assign lo_field = pair_word[`FLD_RIGHT_HI:`FLD_RIGHT_LO];
    assign s_field = sum_word[`FLD_RIGHT_HI:`FLD_RIGHT_LO];

    // Select which stored field feeds each converter
    always_comb begin
        left_code = `OFFSET_ZERO;
        right_code = `OFFSET_ZERO;
        summed_code = `OFFSET_ZERO;
        phase_code = phase_offset_source_select ? s_field : hi_field;
        mode = pickup_cfg_pkg::ROUTE_DIODE;
        if (!summed_input_select) begin
            left_code = hi_field;
            right_code = lo_field;
        end else if (!phase_offset_source_select) begin
            mode = pickup_cfg_pkg::ROUTE_SUM_SHARED;
            summed_code = lo_field;
            phase_code = lo_field;
        end else begin
            mode = pickup_cfg_pkg::ROUTE_SUM_SPLIT;
            summed_code = s_field;
        end
    end
endmodule

// ### hw/pickup_frontend_config_regs.sv
// Design decision made here: the address-and-strobe port.
`include "pickup_cfg_map.svh"
// How it works
// R1: 16-bit word; top nibble picks the register, only that one updates.
// R2: Address nibble two loads the focus offset control register.
// R3: Address nibble three loads the RF path gain register.
// R4: Address nibble four loads the left/right or shared offset register.
// R5: Address nibble five loads the separate summed-channel offset register.
// R6: Focus bit 11 turns the alternate mode off at zero, on at one.
// R7: Focus bit 10 is active low: zero enables the full-range offset source.
// R8: Focus bits 9 to 5 give a linear offset factor 0 to 31/32.
// R9: Gain bits 11:10 pick stage one gain 0/6/12 dB; code 11 reserved.
// R10: Gain bits 9:8 pick stage two gain 6, 12, 18 or 24 dB.
// R11: Gain bits 7:4 pick stage three gain, 0 to 12 dB, 0.8 dB steps.
// R12: Register four bits 11:6 are the left offset while diodes are selected.
// R13: With summed input selected the left offset field is ignored.
// R14: Register four bits 5:0 are the right offset while diodes are selected.
// R15: Summed input, source zero: low field drives phase and summed converters alike.
// R16: Summed input, source one: register four low field is ignored.
// R17: Summed input, source one: register five sets the summed channel offset.
// R18: Summed select picks diode inputs at zero, summed input at one.
// R19: Source bit routes phase offset to register four at zero, five at one.
module pickup_frontend_config_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] addr,
    input wire pickup_cfg_pkg::cfg_word_t wdata,
    input wire logic wr,
    input wire logic rd,
    output pickup_cfg_pkg::cfg_word_t rdata,
    // Mode selects held elsewhere in the device
    input wire logic summed_input_select,
    input wire logic phase_offset_source_select,
    // Focus settings
    output logic alternate_mode_enable,
    output logic focus_full_range_offset_disable_n,
    output logic [4:0] focus_offset_factor,
    // RF gain settings
    output logic [1:0] first_stage_gain,
    output logic [1:0] second_stage_gain,
    output logic [3:0] third_stage_gain,
    // Routed offset codes
    output pickup_cfg_pkg::offset_code_t left_rf_offset_code,
    output pickup_cfg_pkg::offset_code_t right_rf_offset_code,
    output pickup_cfg_pkg::offset_code_t summed_rf_offset_code,
    output pickup_cfg_pkg::offset_code_t phase_detect_channel
);
    pickup_cfg_pkg::cfg_word_t focus_offset_ctrl;
    pickup_cfg_pkg::cfg_word_t rf_stage_gain;
    pickup_cfg_pkg::cfg_word_t rf_pair_offset;
    pickup_cfg_pkg::cfg_word_t rf_sum_offset;
    pickup_cfg_pkg::cfg_word_t next_gain;
    pickup_cfg_pkg::cfg_word_t status_word;
    pickup_cfg_pkg::offset_code_t r_left;
    pickup_cfg_pkg::offset_code_t r_right;
    pickup_cfg_pkg::offset_code_t r_summed;
    pickup_cfg_pkg::offset_code_t r_phase;
    pickup_cfg_pkg::route_e r_mode;
    pickup_cfg_pkg::route_e route_mode;
    logic [3:0] load;
    logic [3:0] word_addr;
    logic gain_reserved;
    logic reserved_seen;
    logic status_read;

    assign word_addr = wdata[`ADDR_HI:`ADDR_LO];

    // One load strobe per register from the word's own address
    cfg_word_decode #(
        .NUM_REGS(4)
    ) u_decode (
        .wr(wr),
        .word(wdata),
        .load(load)
    );

    // Field routing by summed select and source bit
    rf_offset_route u_route (
        .summed_input_select(summed_input_select),
        .phase_offset_source_select(phase_offset_source_select),
        .pair_word(rf_pair_offset),
        .sum_word(rf_sum_offset),
        .left_code(r_left),
        .right_code(r_right),
        .summed_code(r_summed),
        .phase_code(r_phase),
        .mode(r_mode)
    );

    // Focus offset control register
    always_ff @(posedge clk) begin
        if (srst) begin
            focus_offset_ctrl <= `RST_FOCUS;
        end else if (load[0]) begin // [R1] [R2]
            focus_offset_ctrl <= (wdata & `MASK_FOCUS) | `RST_FOCUS & ~`MASK_FOCUS;
        end
    end

    // A reserved stage-one code leaves the previous stage-one gain in place
    always_comb begin
        gain_reserved = wdata[`FLD_FIRST_HI:`FLD_FIRST_LO] == `FIRST_RESERVED;
        next_gain = (wdata & `MASK_GAIN) | (`RST_GAIN & ~`MASK_GAIN);
        if (gain_reserved) begin // [R9]
            next_gain[`FLD_FIRST_HI:`FLD_FIRST_LO] = rf_stage_gain[`FLD_FIRST_HI:`FLD_FIRST_LO];
        end
    end

    // RF path gain register
    always_ff @(posedge clk) begin
        if (srst) begin
            rf_stage_gain <= `RST_GAIN;
        end else if (load[1]) begin // [R1] [R3]
            rf_stage_gain <= next_gain;
        end
    end

    // Left/right or shared offset register
    always_ff @(posedge clk) begin
        if (srst) begin
            rf_pair_offset <= `RST_PAIR;
        end else if (load[2]) begin // [R1] [R4]
            rf_pair_offset <= (wdata & `MASK_PAIR) | `RST_PAIR;
        end
    end

    // Separate summed-channel offset register
    always_ff @(posedge clk) begin
        if (srst) begin
            rf_sum_offset <= `RST_SUM;
        end else if (load[3]) begin // [R1] [R5]
            rf_sum_offset <= (wdata & `MASK_SUM) | `RST_SUM;
        end
    end

    // Sticky flag for a reserved gain write; a new event beats the read clear
    assign status_read = rd && addr == `ADDR_STATUS;
    always_ff @(posedge clk) begin
        if (srst) begin
            reserved_seen <= 1'b0;
        end else if (load[1] && gain_reserved) begin
            reserved_seen <= 1'b1;
        end else if (status_read) begin
            reserved_seen <= 1'b0;
        end
    end

    // Settings straight from the stored words
    assign alternate_mode_enable = focus_offset_ctrl[`FLD_ALT]; // [R6]
    assign focus_full_range_offset_disable_n = focus_offset_ctrl[`FLD_FOFF_DIS]; // [R7]
    assign focus_offset_factor = focus_offset_ctrl[`FLD_BETA_HI:`FLD_BETA_LO]; // [R8]
    assign first_stage_gain = rf_stage_gain[`FLD_FIRST_HI:`FLD_FIRST_LO]; // [R9]
    assign second_stage_gain = rf_stage_gain[`FLD_SECOND_HI:`FLD_SECOND_LO]; // [R10]
    assign third_stage_gain = rf_stage_gain[`FLD_THIRD_HI:`FLD_THIRD_LO]; // [R11]

    // Routed offset codes, registered one cycle after the selects change
    always_ff @(posedge clk) begin
        if (srst) begin
            left_rf_offset_code <= `OFFSET_ZERO;
            right_rf_offset_code <= `OFFSET_ZERO;
            summed_rf_offset_code <= `OFFSET_ZERO;
            phase_detect_channel <= `OFFSET_ZERO;
            route_mode <= pickup_cfg_pkg::ROUTE_DIODE;
        end else begin
            left_rf_offset_code <= r_left; // [R12] [R13] [R18]
            right_rf_offset_code <= r_right; // [R14]
            summed_rf_offset_code <= r_summed; // [R15] [R16] [R17]
            phase_detect_channel <= r_phase; // [R15] [R19]
            route_mode <= r_mode;
        end
    end

    // Status word: reserved flag, routing mode, the two selects
    assign status_word = {`ADDR_STATUS, 7'h00, reserved_seen, 2'(route_mode),
        summed_input_select, phase_offset_source_select};

    // Read data stand for one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst || !rd) begin
            rdata <= `RDATA_ZERO;
        end else begin
            case (addr)
                `ADDR_FOCUS: rdata <= focus_offset_ctrl;
                `ADDR_GAIN: rdata <= rf_stage_gain;
                `ADDR_PAIR: rdata <= rf_pair_offset;
                `ADDR_SUM: rdata <= rf_sum_offset;
                `ADDR_STATUS: rdata <= status_word;
                default: rdata <= `RDATA_ZERO;
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // A configuration write aimed at one address
    sequence s_cfg_write(logic [3:0] a);
        wr && word_addr == a;
    endsequence

    // Selects held for two cycles
    sequence s_sel_held(logic s, logic p);
        summed_input_select == s && phase_offset_source_select == p ##1
        summed_input_select == s && phase_offset_source_select == p;
    endsequence

    a_other_hold: assert property ( // [R1]
        wr && (word_addr < `ADDR_FOCUS || word_addr > `ADDR_SUM) |=>
        $stable(focus_offset_ctrl) && $stable(rf_stage_gain) &&
        $stable(rf_pair_offset) && $stable(rf_sum_offset))
        else $error("Write to another address changed a register");

    a_focus_load: assert property ( // [R2]
        s_cfg_write(`ADDR_FOCUS) |=> focus_offset_ctrl[11:5] == $past(wdata[11:5])
        && $stable(rf_stage_gain))
        else $error("Focus word not loaded");

    a_gain_load: assert property ( // [R3]
        s_cfg_write(`ADDR_GAIN) |=> rf_stage_gain[9:4] == $past(wdata[9:4]))
        else $error("Gain word not loaded");

    a_pair_load: assert property ( // [R4]
        s_cfg_write(`ADDR_PAIR) |=> rf_pair_offset[11:0] == $past(wdata[11:0]))
        else $error("Pair offset word not loaded");

    a_sum_load: assert property ( // [R5]
        s_cfg_write(`ADDR_SUM) |=> rf_sum_offset[5:0] == $past(wdata[5:0])
        && $stable(rf_pair_offset))
        else $error("Sum offset word not loaded");

    a_focus_fields: assert property ( // [R6] [R7] [R8]
        s_cfg_write(`ADDR_FOCUS) |=> alternate_mode_enable == $past(wdata[11]) &&
        focus_full_range_offset_disable_n == $past(wdata[10]) &&
        focus_offset_factor == $past(wdata[9:5]))
        else $error("Focus outputs differ from written word");

    a_first_gain_reserved: assert property ( // [R9]
        s_cfg_write(`ADDR_GAIN) && wdata[11:10] == `FIRST_RESERVED |=>
        $stable(first_stage_gain) && reserved_seen)
        else $error("Reserved stage one code took effect");

    a_gain_fields: assert property ( // [R10] [R11]
        s_cfg_write(`ADDR_GAIN) |=> second_stage_gain == $past(wdata[9:8]) &&
        third_stage_gain == $past(wdata[7:4]))
        else $error("Stage two or three gain wrong");

    a_diode_route: assert property ( // [R12] [R14] [R18]
        s_sel_held(1'b0, phase_offset_source_select) |->
        left_rf_offset_code == $past(rf_pair_offset[11:6]) &&
        right_rf_offset_code == $past(rf_pair_offset[5:0]))
        else $error("Diode offsets not routed");

    a_left_ignored: assert property ( // [R13]
        summed_input_select |=> left_rf_offset_code == 6'h00 &&
        right_rf_offset_code == 6'h00)
        else $error("Left offset used with summed input");

    a_shared_route: assert property ( // [R15]
        s_sel_held(1'b1, 1'b0) |-> summed_rf_offset_code == phase_detect_channel &&
        summed_rf_offset_code == $past(rf_pair_offset[5:0]))
        else $error("Shared offset not driven to both converters");

    a_split_route: assert property ( // [R16] [R17] [R19]
        s_sel_held(1'b1, 1'b1) |-> summed_rf_offset_code == $past(rf_sum_offset[5:0]) &&
        phase_detect_channel == $past(rf_sum_offset[5:0]))
        else $error("Summed offset not taken from register five");

    a_phase_source: assert property ( // [R19]
        s_sel_held(1'b0, 1'b0) |-> phase_detect_channel == $past(rf_pair_offset[11:6]))
        else $error("Phase offset not taken from register four");

    a_read_once: assert property (
        !rd |=> rdata == 16'h0000)
        else $error("Read data outside the answer cycle");

    // Stored words, diode-mode routing, status flag and readback path
    a_stage_one_legal: assert property ( // [R9]
        first_stage_gain != `FIRST_RESERVED)
        else $error("Reserved stage one gain reached the amplifier");

    a_diode_phase_sum: assert property ( // [R19]
        s_sel_held(1'b0, 1'b1) |-> phase_detect_channel == $past(rf_sum_offset[5:0]))
        else $error("Phase offset not taken from register five");

    a_diode_no_sum: assert property ( // [R18]
        !summed_input_select |=> summed_rf_offset_code == 6'h00)
        else $error("Summed offset driven with diode inputs");

    a_unused_zero: assert property ( // [R1]
        focus_offset_ctrl[4:0] == 5'h00 && rf_stage_gain[3:0] == 4'h0 &&
        rf_sum_offset[11:6] == 6'h00)
        else $error("Unused register bits not zero");

    a_flag_clear: assert property (
        status_read && !wr |=> !reserved_seen)
        else $error("Reserved flag survived a status read");

    a_status_read: assert property (
        status_read |=> rdata[15:12] == `ADDR_STATUS && rdata[4] == $past(reserved_seen))
        else $error("Status word not returned");

    a_focus_readback: assert property ( // [R2]
        rd && addr == `ADDR_FOCUS |=> rdata == $past(focus_offset_ctrl))
        else $error("Focus word read back wrong");

    a_gain_readback: assert property ( // [R3]
        rd && addr == `ADDR_GAIN |=> rdata == $past(rf_stage_gain))
        else $error("Gain word read back wrong");
endmodule

// ### verification/host_model.sv
module host_model (
    // Clock and read answer
    input wire logic clk,
    input wire pickup_cfg_pkg::cfg_word_t rdata,
    // Register port toward the block
    output logic [3:0] addr,
    output pickup_cfg_pkg::cfg_word_t wdata,
    output logic wr,
    output logic rd
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle port at time zero
    initial begin
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One whole word, target in its top nibble; called just after an edge
    task automatic write_word(input pickup_cfg_pkg::cfg_word_t w);
        wr <= 1'b1;
        wdata <= w;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~w; // Stale data must not look valid
    endtask

    // Read strobe for one cycle, answer taken in the following cycle
    task automatic read_word(input logic [3:0] a, output pickup_cfg_pkg::cfg_word_t d);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

// ### verification/pickup_frontend_config_regs_bench.sv
module pickup_frontend_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [15:0] word;
        logic sel;
        logic src;
        logic [15:0] exp_rd;
        logic [23:0] exp_codes;
    } row_s;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sel = 1'b0;
    logic src = 1'b0;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    pickup_cfg_pkg::cfg_word_t rdata;
    logic alt;
    logic foff_n;
    logic [4:0] factor;
    logic [1:0] gain_one;
    logic [1:0] gain_two;
    logic [3:0] gain_three;
    pickup_cfg_pkg::offset_code_t left;
    pickup_cfg_pkg::offset_code_t right;
    pickup_cfg_pkg::offset_code_t summed;
    pickup_cfg_pkg::offset_code_t phase;
    pickup_cfg_pkg::cfg_word_t foc;
    pickup_cfg_pkg::cfg_word_t gain;
    pickup_cfg_pkg::cfg_word_t got;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] rst_words [4] = '{16'h2400, 16'h3000, 16'h4000, 16'h5000};
    row_s rows [13] = '{
        '{16'h2abc, 1'b0, 1'b0, 16'h2aa0, 24'h0},
        '{16'h2400, 1'b0, 1'b0, 16'h2400, 24'h0},
        '{16'h3300, 1'b0, 1'b0, 16'h3300, 24'h0},
        '{16'h3500, 1'b0, 1'b0, 16'h3500, 24'h0},
        '{16'h3a50, 1'b0, 1'b0, 16'h3a50, 24'h0},
        '{16'h3c00, 1'b0, 1'b0, 16'h3800, 24'h0},
        '{16'h4fc1, 1'b0, 1'b0, 16'h4fc1, {6'h3f, 6'h01, 6'h00, 6'h3f}},
        '{16'h5f2a, 1'b0, 1'b1, 16'h502a, {6'h3f, 6'h01, 6'h00, 6'h2a}},
        '{16'h4a8e, 1'b1, 1'b0, 16'h4a8e, {6'h00, 6'h00, 6'h0e, 6'h0e}},
        '{16'h5015, 1'b1, 1'b1, 16'h5015, {6'h00, 6'h00, 6'h15, 6'h15}},
        '{16'h4a8e, 1'b0, 1'b0, 16'h4a8e, {6'h2a, 6'h0e, 6'h00, 6'h2a}},
        '{16'h7fff, 1'b0, 1'b1, 16'h0000, {6'h2a, 6'h0e, 6'h00, 6'h15}},
        '{16'h0123, 1'b1, 1'b1, 16'h0000, {6'h00, 6'h00, 6'h15, 6'h15}}
    };

    // Host side of the register port
    host_model i_host_model (
        .clk(clk),
        .rdata(rdata),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd)
    );

    pickup_frontend_config_regs i_pickup_frontend_config_regs (
        .clk(clk),
        .srst(srst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .summed_input_select(sel),
        .phase_offset_source_select(src),
        .alternate_mode_enable(alt),
        .focus_full_range_offset_disable_n(foff_n),
        .focus_offset_factor(factor),
        .first_stage_gain(gain_one),
        .second_stage_gain(gain_two),
        .third_stage_gain(gain_three),
        .left_rf_offset_code(left),
        .right_rf_offset_code(right),
        .summed_rf_offset_code(summed),
        .phase_detect_channel(phase)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // Cuts a hung run short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            $display("CHECK FAILED t=%0t run did not finish", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] g, input logic [23:0] e, input string what);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, g, e);
        end
    endtask

    // Setting outputs against the stored words and the routed codes
    task automatic check_state(input logic [23:0] codes);
        chk({17'h0, alt, foff_n, factor}, {17'h0, foc[11:5]}, "focus");
        chk({16'h0, gain_one, gain_two, gain_three}, {16'h0, gain[11:4]}, "gain");
        chk({left, right, summed, phase}, codes, "offsets");
        chk({left, right, summed, phase}, codes, "routing");
    endtask

    task automatic do_reset();
        srst <= 1'b1;
        sel <= 1'b0;
        src <= 1'b0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        foc = 16'h2400;
        gain = 16'h3000;
        check_state(24'h0);
        @(posedge clk);
        for (int a = 0; a < 4; a++) begin
            i_host_model.read_word(4'(a + 2), got);
            chk({8'h0, got}, {8'h0, rst_words[a]}, "reset word");
            @(posedge clk);
        end
        $display("reset test done");
    endtask

    // Main sequence
    initial begin
        do_reset();
        foreach (rows[i]) begin
            i_host_model.write_word(rows[i].word);
            sel <= rows[i].sel;
            src <= rows[i].src;
            if (rows[i].word[15:12] == 4'h2) begin
                foc = rows[i].word;
            end
            if (rows[i].word[15:12] == 4'h3) begin
                if (rows[i].word[11:10] == 2'h3) begin
                    // Reserved code keeps whatever stage one gain stood before
                    gain = {rows[i].word[15:12], gain[11:10], rows[i].word[9:0]};
                end else begin
                    gain = rows[i].word;
                end
            end
            repeat (3) @(posedge clk);
            #1;
            check_state(rows[i].exp_codes);
            @(posedge clk);
            i_host_model.read_word(rows[i].word[15:12], got);
            chk({8'h0, got}, {8'h0, rows[i].exp_rd}, "readback");
            $display("row %0d done", i);
            @(posedge clk);
        end
        // Write then read with no gap, answer lasting one cycle
        i_host_model.write_word(16'h2fe0);
        i_host_model.read_word(4'h2, got);
        chk({8'h0, got}, 24'h002fe0, "back to back");
        @(posedge clk);
        #1;
        chk({8'h0, rdata}, 24'h0, "answer length");
        $display("back to back test done");
        @(posedge clk);
        // Flag left by the reserved gain row, then cleared by its own read; split mode
        i_host_model.read_word(4'hf, got);
        chk({8'h0, got}, 24'h00f01b, "status flag set");
        @(posedge clk);
        i_host_model.read_word(4'hf, got);
        chk({8'h0, got}, 24'h00f00b, "status flag clear");
        @(posedge clk);
        $display("status test done");
        do_reset();
        close_out();
    end
endmodule
